// file: rtl/rws_sequencer.sv
/*
 * reset and watchdog sequencer: power-on strap check, suspend wait,
 * start-up delays, 2-bit watchdog with hold, cause flags and the
 * registers that reset must clear, reached over avalon-mm.
 * assumes the processor honours cpu_hold, cpu_start and stack_clear,
 * and that the usb engine pulses usb_bus_reset for one cycle.
 */
// Local design decision: the Avalon-MM slave port.
`timescale 1ns/1ps
// Operation
// - any reset restores defaults, zeroes usb address, disables interrupts
// - reset loads both stack pointers with zero
// - reset sources: power-on, watchdog timeout, usb bus reset
// - status register bits 4,5,6 record power-on, usb, watchdog
// - after power-on or watchdog reset fetch starts at address zero
// - reset entry pushes no program counter or flags
// - power-on sets status bit 4
// - power-on puts ports in high-impedance input, samples strap pin
// - strap high and bus idle: suspend until bus activity
// - leaving suspend with strap high: 128 us settling hold
// - strap low at power-on: 96 ms hold, then run
// - delay: strap high 128 us; else flag set 96 ms; else 128 us
// - watchdog fires when upper counter bit rises
// - watchdog reset sets status bit 6
// - watchdog counter advances on 4.096 ms timer tick
// - any write to clear port 0x26 zeroes the watchdog
// - watchdog reset held 2.048 ms before restart at zero
// - usb transmitter off after watchdog until address msb set
module rws_sequencer
#(
	parameter int SETTLE_CYCLES   = rws_pkg::SETTLE_CYC,
	parameter int POWER_CYCLES    = rws_pkg::POWER_CYC,
	parameter int WDR_HOLD_CYCLES = rws_pkg::WDR_HOLD_CYC,
	parameter int US_CYCLES       = rws_pkg::US_CYC
)
(
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        arst_n,
	// avalon-mm slave
	input  wire logic [9:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest,
	// strap and usb line state
	input  wire logic        strap_p37,
	input  wire logic        usb_dm,
	input  wire logic        usb_dp,
	input  wire logic        usb_bus_reset,
	// processor control
	output logic             cpu_hold,
	output logic             cpu_start,
	output logic             stack_clear,
	// device state
	output logic             gpio_hiz,
	output logic [6:0]       usb_dev_addr,
	output logic             usb_tx_en,
	output logic [7:0]       int_enable
);

	// ==========================================================
	// declarations
	logic                                 rst_n;
	logic                                 wdt_tick;
	rws_pkg::rws_state_t                  state_reg;
	logic [rws_pkg::DLY_W-1:0]            dly_reg;
	logic [1:0]                           wdt_cnt_reg;
	logic [7:0]                           usb_addr_reg;
	logic [7:0]                           gie_reg;
	logic [rws_pkg::PSC_FLAGS-1:0]        flag_reg;
	logic [rws_pkg::PSC_FLAGS-1:0]        flag_set;
	logic                                 wait_reg;
	logic [31:0]                          rdata_reg;
	logic                                 hold_reg;
	logic                                 start_reg;
	logic                                 sclr_reg;
	logic                                 hiz_reg;
	logic [7:0]                           idx;
	logic                                 wr_acc;
	logic                                 wr_lo;
	logic                                 clr_acc;
	logic                                 wdr_fire;
	logic                                 soft_rst;
	logic                                 bus_idle;

	// ==========================================================
	// pick the start-up delay, loaded as count minus one
	function automatic logic [rws_pkg::DLY_W-1:0] sel_delay(input logic strap, input logic por_flag);
		logic [rws_pkg::DLY_W-1:0] d;
		d = rws_pkg::DLY_W'(SETTLE_CYCLES - 1);
		if (!strap && por_flag)
			d = rws_pkg::DLY_W'(POWER_CYCLES - 1);
		return d;
	endfunction

	// ==========================================================
	// leaf modules
	rws_rst_sync u_rst
	(
		.sys_clk (sys_clk),
		.arst_n  (arst_n),
		.rst_n   (rst_n)
	);

	rws_us_timer #(.US_CYCLES(US_CYCLES)) u_tmr
	(
		.sys_clk  (sys_clk),
		.rst_n    (rst_n),
		.wdt_tick (wdt_tick)
	);

	// ==========================================================
	// bus decode; a write takes effect at the edge waitrequest is low
	assign idx      = avs_address[9:2];
	assign wr_acc   = avs_write & ~wait_reg;
	assign wr_lo    = wr_acc & avs_byteenable[0];
	assign clr_acc  = wr_acc & (idx == rws_pkg::IDX_WDT_CLR);
	assign bus_idle = usb_dm & ~usb_dp;

	// watchdog fires as the upper bit goes from zero to one
	assign wdr_fire = (state_reg == rws_pkg::ST_RUN) & wdt_tick & ~clr_acc
	                  & (wdt_cnt_reg == rws_pkg::WDT_PRE_FIRE);

	// warm reset sources; power-on comes through the async reset
	assign soft_rst = wdr_fire | usb_bus_reset;

	// ==========================================================
	// fixed one wait state: answer in the cycle after the request
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			wait_reg <= 1'b1;
		else
			wait_reg <= ~((avs_read | avs_write) & wait_reg);
	end

	// read data sampled one cycle ahead; unmapped reads as zero
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			rdata_reg <= rws_pkg::RD_ZERO;
		else if (avs_read & wait_reg)
		begin
			rdata_reg <= rws_pkg::RD_ZERO;
			case (idx)
				rws_pkg::IDX_USB_ADDR: rdata_reg[7:0] <= usb_addr_reg;
				rws_pkg::IDX_GIE:      rdata_reg[7:0] <= gie_reg;
				rws_pkg::IDX_PSC:      rdata_reg[rws_pkg::PSC_FLAG_LO +: rws_pkg::PSC_FLAGS] <= flag_reg;
				default:               rdata_reg <= rws_pkg::RD_ZERO;
			endcase
		end
	end

	// ==========================================================
	// usb address and interrupt enables; reset beats a write
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			usb_addr_reg <= rws_pkg::USB_ADDR_RST;
			gie_reg      <= rws_pkg::GIE_RST;
		end
		else if (soft_rst)
		begin
			usb_addr_reg <= rws_pkg::USB_ADDR_RST;
			gie_reg      <= rws_pkg::GIE_RST;
		end
		else if (wr_lo)
		begin
			if (idx == rws_pkg::IDX_USB_ADDR)
				usb_addr_reg <= avs_writedata[7:0];
			if (idx == rws_pkg::IDX_GIE)
				gie_reg <= avs_writedata[7:0];
		end
	end

	// ==========================================================
	// cause flags: power-on via reset, others by their events
	assign flag_set = {wdr_fire, usb_bus_reset, 1'b0};

	genvar g;
	generate
		for (g = 0; g < rws_pkg::PSC_FLAGS; g++)
		begin : g_flag
			// set wins over a clearing write in the same cycle
			always_ff @(posedge sys_clk or negedge rst_n)
			begin
				if (!rst_n)
					flag_reg[g] <= (g == 0);
				else if (flag_set[g])
					flag_reg[g] <= 1'b1;
				else if (wr_lo && idx == rws_pkg::IDX_PSC)
					flag_reg[g] <= avs_writedata[rws_pkg::PSC_FLAG_LO + g];
			end
		end
	endgenerate

	// ==========================================================
	// 2-bit watchdog; only counts while the processor runs
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			wdt_cnt_reg <= rws_pkg::WDT_RST;
		else if (soft_rst || clr_acc || state_reg != rws_pkg::ST_RUN)
			wdt_cnt_reg <= rws_pkg::WDT_RST;
		else if (wdt_tick)
			wdt_cnt_reg <= wdt_cnt_reg + 1'b1;
	end

	// ==========================================================
	// sequencer: strap check, suspend, delays, run and watchdog hold
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_reg <= rws_pkg::ST_POR_CHECK;
			dly_reg   <= '0;
			hold_reg  <= 1'b1;
			start_reg <= 1'b0;
		end
		else
		begin
			start_reg <= 1'b0;
			case (state_reg)
				rws_pkg::ST_POR_CHECK:
				begin
					// strap sampled only after reset is released
					if (strap_p37 && bus_idle)
						state_reg <= rws_pkg::ST_SUSPEND;
					else
					begin
						dly_reg   <= sel_delay(strap_p37, flag_reg[0]);
						state_reg <= rws_pkg::ST_DELAY;
					end
				end
				rws_pkg::ST_SUSPEND:
				begin
					// any departure from idle (k, se0, bus reset) wakes
					if (!bus_idle)
					begin
						dly_reg   <= sel_delay(strap_p37, flag_reg[0]);
						state_reg <= rws_pkg::ST_DELAY;
					end
				end
				rws_pkg::ST_DELAY, rws_pkg::ST_WDR_HOLD:
				begin
					if (dly_reg == '0)
					begin
						state_reg <= rws_pkg::ST_RUN;
						hold_reg  <= 1'b0;
						start_reg <= 1'b1;
					end
					else
						dly_reg <= dly_reg - 1'b1;
				end
				rws_pkg::ST_RUN:
				begin
					if (wdr_fire)
					begin
						dly_reg   <= rws_pkg::DLY_W'(WDR_HOLD_CYCLES - 1);
						state_reg <= rws_pkg::ST_WDR_HOLD;
						hold_reg  <= 1'b1;
					end
				end
				default:
				begin
					state_reg <= rws_pkg::ST_POR_CHECK;
					hold_reg  <= 1'b1;
				end
			endcase
		end
	end

	// ==========================================================
	// stack clear pulse on every reset; port high-z on power-on and watchdog reset only
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sclr_reg <= 1'b1;
			hiz_reg  <= 1'b1;
		end
		else
		begin
			sclr_reg <= soft_rst;
			if (wdr_fire)
				hiz_reg <= 1'b1;
			else if (start_reg)
				hiz_reg <= 1'b0;
		end
	end

	// ==========================================================
	// outputs straight from flip-flops
	// cpu_start is a plain jump to RESET_VECTOR: nothing is pushed
	assign avs_readdata    = rdata_reg;
	assign avs_waitrequest = wait_reg;
	assign cpu_hold        = hold_reg;
	assign cpu_start       = start_reg;
	assign stack_clear     = sclr_reg;
	assign gpio_hiz        = hiz_reg;
	assign usb_dev_addr    = usb_addr_reg[6:0];
	assign usb_tx_en       = usb_addr_reg[rws_pkg::USB_TX_EN_BIT];
	assign int_enable      = gie_reg;

	// ==========================================================
	// checks
	int unsigned hold_cnt;

	// helper: cycles spent in the watchdog hold
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			hold_cnt <= 0;
		else if (state_reg == rws_pkg::ST_WDR_HOLD)
			hold_cnt <= hold_cnt + 1;
		else
			hold_cnt <= 0;
	end

	sequence s_fire;
		wdr_fire;
	endsequence

	sequence s_hold_end;
		state_reg == rws_pkg::ST_WDR_HOLD ##1 state_reg == rws_pkg::ST_RUN;
	endsequence

	a_wdt_fire_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
		s_fire |=> state_reg == rws_pkg::ST_WDR_HOLD && cpu_hold)
		else $error("watchdog fire did not hold the processor");

	a_wdr_hold_len: assert property (@(posedge sys_clk) disable iff (!rst_n)
		s_hold_end |-> $past(hold_cnt) == WDR_HOLD_CYCLES - 1 && cpu_start)
		else $error("watchdog hold length wrong");

	a_wdr_flag_set: assert property (@(posedge sys_clk) disable iff (!rst_n)
		s_fire |=> flag_reg[2] && stack_clear)
		else $error("watchdog flag or stack clear missing");

	a_wdt_clear_port: assert property (@(posedge sys_clk) disable iff (!rst_n)
		clr_acc |=> wdt_cnt_reg == rws_pkg::WDT_RST)
		else $error("clear port did not zero watchdog");

	a_wdt_tick_adv: assert property (@(posedge sys_clk) disable iff (!rst_n)
		state_reg == rws_pkg::ST_RUN && wdt_tick && !clr_acc && !soft_rst
		|=> wdt_cnt_reg == $past(wdt_cnt_reg) + 2'h1)
		else $error("watchdog did not advance on tick");

	a_usb_tx_off: assert property (@(posedge sys_clk) disable iff (!rst_n)
		s_fire |=> !usb_tx_en && usb_dev_addr == '0 && int_enable == '0)
		else $error("usb address or enables not cleared");

	a_start_release: assert property (@(posedge sys_clk) disable iff (!rst_n)
		cpu_start |-> !cpu_hold && $past(cpu_hold) && gpio_hiz ##1 !gpio_hiz)
		else $error("start pulse without hold release");

	a_suspend_entry: assert property (@(posedge sys_clk) disable iff (!rst_n)
		state_reg == rws_pkg::ST_POR_CHECK && strap_p37 && bus_idle
		|=> state_reg == rws_pkg::ST_SUSPEND && cpu_hold)
		else $error("suspend not entered");

	a_settle_pick: assert property (@(posedge sys_clk) disable iff (!rst_n)
		state_reg == rws_pkg::ST_SUSPEND && !bus_idle && strap_p37
		|=> dly_reg == rws_pkg::DLY_W'(SETTLE_CYCLES - 1))
		else $error("wrong settle delay after suspend");

	a_power_pick: assert property (@(posedge sys_clk) disable iff (!rst_n)
		state_reg == rws_pkg::ST_POR_CHECK && !strap_p37 && flag_reg[0]
		|=> state_reg == rws_pkg::ST_DELAY && dly_reg == rws_pkg::DLY_W'(POWER_CYCLES - 1))
		else $error("wrong power-up delay");

endmodule

// file: rtl/rws_pkg.sv
/*
 * constants shared by the reset and watchdog sequencer: register indices,
 * field positions, reset values, timing figures and the sequencer states.
 * assumes a 200 MHz system clock and 32-bit avalon-mm word access.
 */
package rws_pkg;

	// ==========================================================
	// clock and timing
	localparam int CLK_HZ        = 200_000_000;
	localparam int US_CYC        = CLK_HZ / 1_000_000;
	localparam int SETTLE_US     = 128;
	localparam int POWER_MS      = 96;
	localparam int WDR_HOLD_US   = 2_048;  // 2.048 ms
	localparam int SETTLE_CYC    = SETTLE_US * US_CYC;
	localparam int POWER_CYC     = POWER_MS * (CLK_HZ / 1_000);
	localparam int WDR_HOLD_CYC  = WDR_HOLD_US * US_CYC;
	localparam int DLY_W         = 25;
	localparam int US_TMR_W      = 12;
	localparam int US_TICK_BIT   = 11;
	localparam int PRE_W         = 8;

	// ==========================================================
	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_USB_ADDR = 8'h10;
	localparam logic [7:0] IDX_GIE      = 8'h20;
	localparam logic [7:0] IDX_WDT_CLR  = 8'h26;
	localparam logic [7:0] IDX_PSC      = 8'hff;

	// ==========================================================
	// fields and reset values
	localparam int         PSC_POR_BIT   = 4;
	localparam int         PSC_FLAG_LO   = 4;
	localparam int         PSC_FLAGS     = 3;
	localparam int         USB_TX_EN_BIT = 7;
	localparam int         WDT_MSB       = 1;
	localparam logic [1:0] WDT_PRE_FIRE  = 2'h1;
	localparam logic [1:0] WDT_RST       = 2'h0;
	localparam logic [7:0] USB_ADDR_RST  = 8'h00;
	localparam logic [7:0] GIE_RST       = 8'h00;
	localparam logic [7:0] STACK_RST     = 8'h00;
	localparam logic [15:0] RESET_VECTOR = 16'h0000;
	localparam logic [31:0] RD_ZERO      = 32'h0000_0000;

	// ==========================================================
	// sequencer states
	typedef enum logic [2:0] {
		ST_POR_CHECK,
		ST_SUSPEND,
		ST_DELAY,
		ST_RUN,
		ST_WDR_HOLD
	} rws_state_t;

endpackage

// file: rtl/rws_rst_sync.sv
/*
 * reset release synchroniser: asserts at once, releases after two edges.
 * assumes arst_n may fall at any time relative to sys_clk.
 */
`timescale 1ns/1ps
module rws_rst_sync
(
	// clock and raw reset
	input  wire logic sys_clk,
	input  wire logic arst_n,
	// released copy
	output logic      rst_n
);

	logic meta_reg;

	// ==========================================================
	// two stages; only the second stage reads the first
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			meta_reg <= 1'b0;
			rst_n    <= 1'b0;
		end
		else
		begin
			meta_reg <= 1'b1;
			rst_n    <= meta_reg;
		end
	end

endmodule

// file: rtl/rws_us_timer.sv
/*
 * free-running microsecond timer; pulses when its bit 11 rises (4.096 ms).
 * assumes an active-low reset from the top module, asserted at once and released on the clock.
 */
`timescale 1ns/1ps
module rws_us_timer
#(
	// system clocks per microsecond; a bench may shorten it to reach ticks sooner
	parameter int US_CYCLES = rws_pkg::US_CYC
)
(
	// clock and reset
	input  wire logic sys_clk,
	input  wire logic rst_n,
	// one-cycle tick
	output logic      wdt_tick
);

	logic [rws_pkg::PRE_W-1:0]    pre_reg;
	logic [rws_pkg::US_TMR_W-1:0] us_reg;
	logic                         msb_reg;

	// ==========================================================
	// prescaler to one microsecond, then the 12-bit count
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pre_reg <= '0;
			us_reg  <= '0;
		end
		else if (pre_reg == rws_pkg::PRE_W'(US_CYCLES - 1))
		begin
			pre_reg <= '0;
			us_reg  <= us_reg + 1'b1;
		end
		else
			pre_reg <= pre_reg + 1'b1;
	end

	// rising edge of bit 11 gives the watchdog clock
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			msb_reg  <= 1'b0;
			wdt_tick <= 1'b0;
		end
		else
		begin
			msb_reg  <= us_reg[rws_pkg::US_TICK_BIT];
			wdt_tick <= us_reg[rws_pkg::US_TICK_BIT] & ~msb_reg;
		end
	end

endmodule

// file: testbench/rws_usb_host.sv
/*
 * usb host side model: drives the line pair and the bus reset pulse.
 * assumes the bench picks the line state and requests reset pulses.
 */
`timescale 1ns/1ps
module rws_usb_host
(
	// clock
	input  wire logic       sys_clk,
	// bench commands: 0 idle, 1 k state, 2 se0
	input  wire logic [1:0] line_mode,
	input  wire logic       reset_req,
	// line state towards the device
	output logic            usb_dm,
	output logic            usb_dp,
	output logic            usb_bus_reset
);
	// ==========================================================
	// line levels, registered like a real transceiver edge
	always_ff @(posedge sys_clk)
	begin
		usb_dm <= (line_mode == 2'h0);
		usb_dp <= (line_mode == 2'h1);
	end

	// bus reset is signalled as a one-cycle pulse, not a pin
	always_ff @(posedge sys_clk)
	begin
		usb_bus_reset <= reset_req;
	end
endmodule

// file: testbench/test_reset_and_watchdog_sequencer.sv
/*
 * self-checking bench for the reset and watchdog sequencer.
 * assumes short delay parameters and a fast microsecond prescaler, so ticks come soon.
 */
`timescale 1ns/1ps
module test_reset_and_watchdog_sequencer;
	// ==========================================================
	// settings and signals
	localparam int SET_C = 8;
	localparam int PWR_C = 20;
	localparam int HOLD_C = 10;
	localparam int US_C = 2;
	localparam int TICK_C = 4096 * US_C;
	localparam int LIMIT = 80000;
	logic        sys_clk, arst_n, avs_read, avs_write, avs_waitrequest, strap_p37, reset_req;
	logic [9:0]  avs_address;
	logic [31:0] avs_writedata, avs_readdata, q;
	logic [3:0]  avs_byteenable;
	logic        usb_dm, usb_dp, usb_bus_reset, cpu_hold, cpu_start, stack_clear, gpio_hiz, usb_tx_en;
	logic [6:0]  usb_dev_addr;
	logic [7:0]  int_enable, v;
	logic [1:0]  line_mode;
	int          err_count, n_compared, cyc, seed, n;

	rws_sequencer #(.SETTLE_CYCLES(SET_C), .POWER_CYCLES(PWR_C), .WDR_HOLD_CYCLES(HOLD_C), .US_CYCLES(US_C)) dut (
		.sys_clk(sys_clk), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .strap_p37(strap_p37),
		.usb_dm(usb_dm), .usb_dp(usb_dp), .usb_bus_reset(usb_bus_reset), .cpu_hold(cpu_hold),
		.cpu_start(cpu_start), .stack_clear(stack_clear), .gpio_hiz(gpio_hiz),
		.usb_dev_addr(usb_dev_addr), .usb_tx_en(usb_tx_en), .int_enable(int_enable));
	rws_usb_host host (.sys_clk(sys_clk), .line_mode(line_mode), .reset_req(reset_req),
		.usb_dm(usb_dm), .usb_dp(usb_dp), .usb_bus_reset(usb_bus_reset));

	// ==========================================================
	// clock and hang guard
	initial
	begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk)
	begin
		cyc++;
		if (cyc == LIMIT)
		begin
			err_count++;
			end_of_test();
		end
	end

	// ==========================================================
	// tasks and expectations
	task automatic end_of_test();
		$display("compared %0d, mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_compared++;
		if (got !== exp)
		begin
			err_count++;
			$display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask
	// one avalon cycle: hold everything until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] d, input logic [3:0] be);
		int k;
		k = 0;
		@(posedge sys_clk);
		avs_address <= {idx, 2'b00};
		avs_read <= ~wr;
		avs_write <= wr;
		avs_writedata <= {24'h00_0000, d};
		avs_byteenable <= be;
		// only the global cycle limit ends a wait that never answers
		do
		begin
			@(posedge sys_clk);
			k++;
		end
		while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		chk(k, 2, "bus answer");
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		bus(1'b1, idx, d, 4'h1);
	endtask
	task automatic rdc(input logic [7:0] idx, input logic [7:0] exp, input string what);
		bus(1'b0, idx, 8'h00, 4'h1);
		chk(q, {24'h00_0000, exp}, what);
	endtask
	task automatic apply_reset(input logic s, input logic [1:0] m);
		arst_n <= 1'b0;
		strap_p37 <= s;
		line_mode <= m;
		repeat (16) @(posedge sys_clk);
		chk({cpu_hold, cpu_start, stack_clear, gpio_hiz, usb_tx_en, usb_dev_addr, int_enable},
			{5'b10110, 15'h0000}, "outputs in reset");
		arst_n <= 1'b1;
	endtask
	// count cycles to the start pulse, then check the release
	task automatic to_start(input int exp);
		n = 0;
		while (cpu_start !== 1'b1 && n < 10000) begin @(posedge sys_clk); n++; end
		chk(n >= exp - 1 && n <= exp + 8, 1, "start delay");
		repeat (2) @(posedge sys_clk);
		chk({cpu_hold, gpio_hiz}, 2'b00, "running");
	endtask
	function automatic int exp_delay(input logic s, input logic flag);
		return (s || !flag) ? SET_C : PWR_C;
	endfunction

	// ==========================================================
	// main sequence
	initial
	begin
		{arst_n, avs_read, avs_write, strap_p37, reset_req} = 5'b00000;
		{avs_address, avs_writedata, avs_byteenable, line_mode} = '0;
		{err_count, n_compared, cyc} = '0;
		seed = 32'h4b08bbb1;
		// strap low: long power hold, then defaults
		apply_reset(1'b0, 2'h0);
		to_start(exp_delay(1'b0, 1'b1) + 3);
		// stacks start at zero; the stack clear pulse has ended by now
		chk(stack_clear, 1'b0, "stack pointers free");
		rdc(rws_pkg::IDX_PSC, 8'h10, "power flag");
		rdc(rws_pkg::IDX_USB_ADDR, 8'h00, "usb addr");
		rdc(rws_pkg::IDX_GIE, 8'h00, "int enable");
		// strap high with se0: short settle only
		apply_reset(1'b1, 2'h2);
		to_start(exp_delay(1'b1, 1'b1) + 3);
		// strap high, idle bus: suspend until k
		apply_reset(1'b1, 2'h0);
		repeat (60) @(posedge sys_clk);
		chk({cpu_hold, cpu_start}, 2'b10, "suspended");
		line_mode <= 2'h1;
		to_start(exp_delay(1'b1, 1'b1) + 1);
		// random register traffic
		repeat (8)
		begin
			v = 8'($random(seed));
			wr(rws_pkg::IDX_USB_ADDR, v);
			wr(rws_pkg::IDX_GIE, ~v);
			rdc(rws_pkg::IDX_USB_ADDR, v, "usb addr rw");
			chk({usb_tx_en, usb_dev_addr, int_enable}, {v, ~v}, "addr pins");
		end
		// refused and unmapped accesses
		bus(1'b1, rws_pkg::IDX_GIE, 8'h5a, 4'h0);
		rdc(rws_pkg::IDX_GIE, ~v, "no byte enable");
		wr(8'h33, 8'hff);
		rdc(8'h33, 8'h00, "unmapped");
		rdc(rws_pkg::IDX_WDT_CLR, 8'h00, "clear port read");
		// firmware clears the power flag before sleeping
		wr(rws_pkg::IDX_PSC, 8'h00);
		rdc(rws_pkg::IDX_PSC, 8'h00, "flag cleared");
		// usb bus reset clears state without stopping the cpu
		wr(rws_pkg::IDX_USB_ADDR, 8'h85);
		wr(rws_pkg::IDX_GIE, 8'hff);
		reset_req <= 1'b1;
		@(posedge sys_clk);
		reset_req <= 1'b0;
		repeat (3) @(posedge sys_clk);
		chk({cpu_hold, usb_tx_en, usb_dev_addr, int_enable}, 0, "usb reset");
		rdc(rws_pkg::IDX_PSC, 8'h20, "usb flag");
		// regular clears, with any data and no byte enable, keep it quiet
		// gaps below one tick period, so at most one tick lands between clears
		repeat (4)
		begin
			bus(1'b1, rws_pkg::IDX_WDT_CLR, 8'($random(seed)), 4'h0);
			repeat (TICK_C - 100) @(posedge sys_clk);
			chk(cpu_hold, 1'b0, "watchdog cleared");
		end
		// stop clearing: the second tick after the last clear fires
		wr(rws_pkg::IDX_USB_ADDR, 8'h85);
		bus(1'b1, rws_pkg::IDX_WDT_CLR, 8'h00, 4'h0);
		n = 0;
		while (cpu_hold !== 1'b1 && n < 2 * TICK_C + 100)
		begin
			@(posedge sys_clk);
			n++;
		end
		chk(n >= TICK_C + 2 && n <= 2 * TICK_C + 1, 1, "fire time");
		chk({usb_tx_en, usb_dev_addr, gpio_hiz, stack_clear}, 10'h003, "watchdog reset");
		to_start(HOLD_C);
		rdc(rws_pkg::IDX_PSC, 8'h60, "watchdog flag");
		chk(usb_tx_en, 1'b0, "tx off");
		wr(rws_pkg::IDX_USB_ADDR, 8'h80);
		rdc(rws_pkg::IDX_USB_ADDR, 8'h80, "tx bit");
		chk(usb_tx_en, 1'b1, "tx on");
		end_of_test();
	end
endmodule
